//--- hw/sdbp_ahb_slave.sv
`timescale 1ns/1ps
module sdbp_ahb_slave (
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic                hready,
	input  wire logic [31:0]         rdata,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	output sdbp_pkg::sdbp_req_t      req
);
	import sdbp_pkg::*;

	sdbp_req_t   ph_q, ph_d;
	logic        rdy_q, rdy_d;
	logic [31:0] rd_q, rd_d;
	logic        hit;

	// ----------------------------------------
	// Address and data phase
	// ----------------------------------------
	always_comb
	begin
		ph_d  = '0;
		rdy_d = rdy_q;
		rd_d  = rd_q;
		hit   = (haddr[1:0] == 2'b00) && (haddr[31:ADDR_IDX_MSB+1] == '0) && (hsize != 3'h7);
		if (ph_q.valid && !ph_q.write && !rdy_q)
		begin
			rd_d  = rdata;
			rdy_d = 1'b1;
		end
		else if (hsel && hready && (htrans == HTRANS_NONSEQ))
		begin
			ph_d.valid = 1'b1;
			ph_d.write = hwrite;
			ph_d.idx   = hit ? haddr[ADDR_IDX_MSB:ADDR_IDX_LSB] : IDX_NONE;
			rdy_d      = hwrite;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ph_q  <= '0;
			rdy_q <= 1'b1;
			rd_q  <= '0;
		end
		else
		begin
			ph_q  <= ph_d;
			rdy_q <= rdy_d;
			rd_q  <= rd_d;
		end
	end

	assign hreadyout = rdy_q;
	assign hresp     = HRESP_OKAY;
	assign hrdata    = rd_q;
	assign req       = (ph_q.valid && (ph_q.write || !rdy_q)) ? ph_q : '0;

endmodule // sdbp_ahb_slave

//--- hw/sdbp_pkg.sv
package sdbp_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W  = 16;
	localparam int LEN_W   = 4;
	localparam int BAUD_W  = 7;
	localparam int IDX_W   = 16;

	// ----------------------------------------
	// Register indices, byte address is index * 4
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_NONE = 16'h0000;
	localparam logic [IDX_W-1:0] IDX_CTL  = 16'h7041;
	localparam logic [IDX_W-1:0] IDX_STS  = 16'h7042;
	localparam logic [IDX_W-1:0] IDX_EMU  = 16'h7046;
	localparam logic [IDX_W-1:0] IDX_RXB  = 16'h7047;
	localparam logic [IDX_W-1:0] IDX_TXB  = 16'h7048;
	localparam logic [IDX_W-1:0] IDX_SDAT = 16'h7049;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTL_LEN_LSB  = 0;
	localparam int CTL_RUN_BIT  = 7;
	localparam int CTL_MST_BIT  = 8;
	localparam int CTL_TALK_BIT = 9;
	localparam int CTL_BAUD_LSB = 10;
	localparam int STS_TXF_BIT  = 5;
	localparam int STS_CC_BIT   = 6;
	localparam logic [31:0] CTL_RST  = 32'h0000_008f;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [BAUD_W-1:0] BAUD_MIN = 7'h03;

	// ----------------------------------------
	// AHB-Lite encodings
	// ----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic       HRESP_OKAY    = 1'b0;
	localparam int         ADDR_IDX_LSB  = 2;
	localparam int         ADDR_IDX_MSB  = 17;

	typedef struct packed {
		logic             valid;
		logic             write;
		logic [IDX_W-1:0] idx;
	} sdbp_req_t;

endpackage

//--- hw/sdbp_shifter.sv
`timescale 1ns/1ps
module sdbp_shifter #(
	parameter int W = 16
) (
	input  wire logic                         ref_clk,
	input  wire logic                         rst,
	input  wire logic                         load,
	input  wire logic [W-1:0]                 load_word,
	input  wire logic                         master,
	input  wire logic                         run,
	input  wire logic [sdbp_pkg::LEN_W-1:0]   len_m1,
	input  wire logic [sdbp_pkg::BAUD_W-1:0]  baud,
	input  wire logic                         sclk_s,
	input  wire logic                         sdi_s,
	output logic [W-1:0]                      shift_word,
	output logic                              active,
	output logic                              done,
	output logic                              sclk,
	output logic                              sdo
);
	import sdbp_pkg::*;

	logic [W-1:0]      sh_q, sh_d;
	logic              act_q, act_d, done_q, done_d, sclk_q, sclk_d;
	logic              smp_q, smp_d, prev_q;
	logic [LEN_W-1:0]  cnt_q, cnt_d;
	logic [BAUD_W-1:0] div_q, div_d, brr, half;
	logic              rise, fall, bit_in;

	// ----------------------------------------
	// Bit clock and shift
	// ----------------------------------------
	always_comb
	begin
		sh_d   = sh_q;
		act_d  = act_q;
		cnt_d  = cnt_q;
		div_d  = div_q;
		sclk_d = sclk_q;
		smp_d  = smp_q;
		done_d = 1'b0;
		brr    = (baud < BAUD_MIN) ? BAUD_MIN : baud;
		half   = (brr >> 1) + {{(BAUD_W-1){1'b0}}, brr[0]};
		bit_in = master ? sdi_s : smp_q;
		if (master)
		begin
			rise = act_q && (div_q == '0);
			fall = act_q && (div_q == half);
			if (act_q)
				div_d = (div_q == brr) ? '0 : div_q + 7'h01;
			if (rise)
				sclk_d = 1'b1;
			if (fall)
				sclk_d = 1'b0;
		end
		else
		begin
			rise = sclk_s && !prev_q;
			fall = !sclk_s && prev_q;
			if (rise)
				act_d = 1'b1;
		end
		if (rise)
			smp_d = sdi_s;
		if (fall && act_q)
		begin
			sh_d = {sh_q[W-2:0], bit_in};
			if (cnt_q == len_m1)
			begin
				act_d  = 1'b0;
				done_d = 1'b1;
				cnt_d  = '0;
				div_d  = '0;
			end
			else
				cnt_d = cnt_q + 4'h1;
		end
		if (!run)
		begin
			act_d  = 1'b0;
			cnt_d  = '0;
			div_d  = '0;
			sclk_d = 1'b0;
		end
		if (load)
		begin
			sh_d  = load_word;
			cnt_d = '0;
			div_d = '0;
			if (master && run)
				act_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sh_q   <= WORD_RST;
			act_q  <= 1'b0;
			cnt_q  <= '0;
			div_q  <= '0;
			sclk_q <= 1'b0;
			smp_q  <= 1'b0;
			done_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			sh_q   <= sh_d;
			act_q  <= act_d;
			cnt_q  <= cnt_d;
			div_q  <= div_d;
			sclk_q <= sclk_d;
			smp_q  <= smp_d;
			done_q <= done_d;
			prev_q <= sclk_s;
		end
	end

	assign shift_word = sh_q;
	assign active     = act_q;
	assign done       = done_q;
	assign sclk       = sclk_q;
	assign sdo        = sh_q[W-1];

	chk_msb_first: assert property (@(posedge ref_clk) disable iff (rst)
		fall && act_q && !load && run |=> sh_q == {$past(sh_q[W-2:0]), $past(bit_in)})
		else $error("shift did not move toward msb with sampled bit");

endmodule // sdbp_shifter

//--- hw/sdbp_top.sv
`timescale 1ns/1ps
module sdbp_top #(
	parameter int DW = 16
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire logic              sclk_i,
	output logic                   sclk_o,
	output logic                   sclk_oe,
	input  wire logic              sdi_i,
	output logic                   sdo_o,
	output logic                   sdo_oe
);
	import sdbp_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sdbp_req_t     req;
	logic [31:0]   rdata;
	logic [31:0]   ctl_q, ctl_d;
	logic [DW-1:0] rx_q, rx_d, tx_q, tx_d;
	logic          cc_q, cc_d, pend_q, pend_d;
	logic [1:0]    sclk_sync_q, sdi_sync_q;
	logic          load;
	logic [DW-1:0] load_word, shift_word;
	logic          active, done, sclk_int, sdo_int;
	logic          wr_ctl, wr_tx, rd_rxb;
	logic          run, master;

	function automatic logic is_acc(input sdbp_req_t r, input logic wr,
		input logic [IDX_W-1:0] idx);
		is_acc = r.valid && (r.write == wr) && (r.idx == idx);
	endfunction

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	sdbp_ahb_slave i_sdbp_ahb_slave (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.rdata     (rdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.req       (req)
	);

	assign wr_ctl = is_acc(req, 1'b1, IDX_CTL);
	assign wr_tx  = is_acc(req, 1'b1, IDX_TXB);
	assign rd_rxb = is_acc(req, 1'b0, IDX_RXB);
	assign run    = ctl_q[CTL_RUN_BIT];
	assign master = ctl_q[CTL_MST_BIT];

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		rdata = '0;
		case (req.idx)
			IDX_CTL:  rdata = ctl_q;
			IDX_STS:
			begin
				rdata[STS_CC_BIT]  = cc_q;
				rdata[STS_TXF_BIT] = pend_q;
			end
			IDX_EMU:  rdata = {16'h0000, rx_q};
			IDX_RXB:  rdata = {16'h0000, rx_q};
			IDX_TXB:  rdata = {16'h0000, tx_q};
			IDX_SDAT: rdata = {16'h0000, shift_word};
			default:  rdata = '0;
		endcase
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sclk_sync_q <= 2'b00;
			sdi_sync_q  <= 2'b00;
		end
		else
		begin
			sclk_sync_q <= {sclk_sync_q[0], sclk_i};
			sdi_sync_q  <= {sdi_sync_q[0], sdi_i};
		end
	end

	// ----------------------------------------
	// Buffers and flags
	// ----------------------------------------
	always_comb
	begin
		ctl_d     = ctl_q;
		rx_d      = rx_q;
		tx_d      = tx_q;
		cc_d      = cc_q;
		pend_d    = pend_q;
		load      = 1'b0;
		load_word = tx_q;
		if (wr_ctl)
			ctl_d = hwdata;
		if (rd_rxb)
			cc_d = 1'b0;
		if (done)
		begin
			rx_d = shift_word;
			cc_d = 1'b1;
		end
		if (done && pend_q)
		begin
			load      = 1'b1;
			load_word = tx_q;
			pend_d    = 1'b0;
		end
		if (wr_tx)
		begin
			tx_d = hwdata[DW-1:0];
			if (active || load)
				pend_d = 1'b1;
			else
			begin
				load      = 1'b1;
				load_word = hwdata[DW-1:0];
			end
		end
		if (!run)
		begin
			cc_d   = 1'b0;
			pend_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctl_q  <= CTL_RST;
			rx_q   <= WORD_RST;
			tx_q   <= WORD_RST;
			cc_q   <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			ctl_q  <= ctl_d;
			rx_q   <= rx_d;
			tx_q   <= tx_d;
			cc_q   <= cc_d;
			pend_q <= pend_d;
		end
	end

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	sdbp_shifter #(
		.W (DW)
	) i_sdbp_shifter (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.load       (load),
		.load_word  (load_word),
		.master     (master),
		.run        (run),
		.len_m1     (ctl_q[CTL_LEN_LSB +: LEN_W]),
		.baud       (ctl_q[CTL_BAUD_LSB +: BAUD_W]),
		.sclk_s     (sclk_sync_q[1]),
		.sdi_s      (sdi_sync_q[1]),
		.shift_word (shift_word),
		.active     (active),
		.done       (done),
		.sclk       (sclk_int),
		.sdo        (sdo_int)
	);

	assign sclk_o  = sclk_int;
	assign sclk_oe = ctl_q[CTL_MST_BIT];
	assign sdo_o   = sdo_int;
	assign sdo_oe  = ctl_q[CTL_TALK_BIT];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_rx_capture: assert property (@(posedge ref_clk) disable iff (rst)
		done && run |=> rx_q == $past(shift_word) && cc_q)
		else $error("completed character not captured with flag");

	chk_rxb_clear: assert property (@(posedge ref_clk) disable iff (rst)
		rd_rxb && !done |=> !cc_q)
		else $error("receive holding read did not clear flag");

	chk_emu_keep: assert property (@(posedge ref_clk) disable iff (rst)
		is_acc(req, 1'b0, IDX_EMU) && !done && run |=> cc_q == $past(cc_q))
		else $error("mirror read changed complete flag");

	chk_emu_data: assert property (@(posedge ref_clk) disable iff (rst)
		is_acc(req, 1'b0, IDX_EMU) |=> hrdata == {16'h0000, rx_q} && hreadyout
			&& pend_q == $past(pend_q) || $past(done) || $past(wr_tx))
		else $error("mirror read data wrong or state disturbed");

	chk_tx_pend: assert property (@(posedge ref_clk) disable iff (rst)
		wr_tx && active && run |=> pend_q && tx_q == $past(hwdata[DW-1:0]))
		else $error("busy transmit write did not set pending");

	chk_auto_load: assert property (@(posedge ref_clk) disable iff (rst)
		done && pend_q && !wr_tx && run |=> !pend_q && shift_word == $past(tx_q))
		else $error("pending word not moved into shifter");

	chk_direct_load: assert property (@(posedge ref_clk) disable iff (rst)
		wr_tx && !active && !(done && pend_q) |=> !pend_q
			&& shift_word == $past(hwdata[DW-1:0]))
		else $error("idle transmit write did not fall through");

	chk_master_start: assert property (@(posedge ref_clk) disable iff (rst)
		wr_tx && !active && !done && master && run |=> active ##1 sclk_o)
		else $error("master transmit write did not start transfer");

	chk_pend_reset: assert property (@(posedge ref_clk)
		rst |=> !pend_q && !cc_q)
		else $error("flags not cleared by reset");

	chk_sts_ro: assert property (@(posedge ref_clk) disable iff (rst)
		is_acc(req, 1'b1, IDX_STS) && !done && !wr_tx |=> pend_q == $past(pend_q))
		else $error("status write changed pending flag");

	chk_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
		done && rd_rxb && run |=> cc_q)
		else $error("complete flag lost when read met new character");

	chk_read_data: assert property (@(posedge ref_clk) disable iff (rst)
		req.valid && !req.write |=> hreadyout && hrdata == $past(rdata))
		else $error("read data not presented after one wait cycle");

	chk_run_clear: assert property (@(posedge ref_clk) disable iff (rst)
		!run |=> !pend_q && !cc_q)
		else $error("flags not cleared while run is low");

	cov_char_done:  cover property (@(posedge ref_clk) disable iff (rst) done);
	cov_start:      cover property (@(posedge ref_clk) disable iff (rst) wr_tx && master && !active);
	cov_emu_read:   cover property (@(posedge ref_clk) disable iff (rst) is_acc(req, 1'b0, IDX_EMU));
	cov_chained:    cover property (@(posedge ref_clk) disable iff (rst) done && pend_q);
	cov_rxb_read:   cover property (@(posedge ref_clk) disable iff (rst) rd_rxb && cc_q);

endmodule // sdbp_top

//--- tb/sdbp_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side serial device
// ----------------------------------------
module sdbp_far_model (
	input  wire logic        arm,
	input  wire logic [4:0]  nbits,
	input  wire logic [15:0] reply,
	input  wire logic        sclk,
	input  wire logic        sdo,
	output logic             sdi,
	output logic [15:0]      heard
);
	logic [15:0] sh, acc;
	logic [4:0]  cnt;

	// Shift on falling edge, idle fill flips each bit
	always @(negedge sclk or posedge arm)
	begin
		if (arm)
			sh <= reply;
		else
			sh <= {sh[14:0], ~sh[15]};
	end

	assign sdi = sh[15];

	// Sample on rising edge, msb first; publish whole character
	always @(posedge sclk or posedge arm)
	begin
		if (arm)
		begin
			heard <= 16'h0000;
			acc   <= 16'h0000;
			cnt   <= 5'd0;
		end
		else if (cnt == nbits - 5'd1)
		begin
			heard <= {acc[14:0], sdo};
			acc   <= 16'h0000;
			cnt   <= 5'd0;
		end
		else
		begin
			acc <= {acc[14:0], sdo};
			cnt <= cnt + 5'd1;
		end
	end
endmodule // sdbp_far_model

//--- tb/spi_data_buffer_path_tb.sv
`timescale 1ns/1ps
module spi_data_buffer_path_tb;
	import sdbp_pkg::*;

	logic        ref_clk, rst, hsel, hwrite, arm;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, sclk_o, sclk_oe, sdi_i, sdo_o, sdo_oe;
	logic [15:0] reply, heard;
	logic [4:0]  nbits;
	int          fail_count, n_compared, cyc;

	sdbp_top i_sdbp_top (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sclk_i(1'b0), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sdi_i(sdi_i),
		.sdo_o(sdo_o), .sdo_oe(sdo_oe));

	sdbp_far_model i_sdbp_far_model (.arm(arm), .nbits(nbits), .reply(reply), .sclk(sclk_o),
		.sdo(sdo_o), .sdi(sdi_i), .heard(heard));

	// ----------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			test_done();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {14'h0000, idx, 2'b00};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0000_0000);
		chk(name, exp, rd);
	endtask

	task automatic start(input logic [15:0] r, input logic [4:0] n);
		reply <= r;
		nbits <= n;
		arm   <= 1'b1;
		@(posedge ref_clk);
		arm   <= 1'b0;
	endtask

	task automatic wait_cc();
		int n;
		n = 0;
		do
		begin
			bus(1'b0, IDX_STS, 32'h0000_0000);
			n++;
		end
		while (rd[STS_CC_BIT] !== 1'b1 && n < 200);
		chk("char complete", 32'h1, {31'h0, rd[STS_CC_BIT]});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk("rx holding", IDX_RXB, 32'h0000_0000);
		rdchk("mirror", IDX_EMU, 32'h0000_0000);
		rdchk("tx holding", IDX_TXB, 32'h0000_0000);
		rdchk("status", IDX_STS, 32'h0000_0000);
		rdchk("control", IDX_CTL, CTL_RST);
		rdchk("unmapped", 16'h7000, 32'h0000_0000);
		chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
		$display("test reset done");
	endtask

	task automatic t_full();
		bus(1'b1, IDX_CTL, 32'h0000_0f8f);
		start(16'ha5c3, 5'd16);
		bus(1'b1, IDX_TXB, 32'h0000_3c5a);
		rdchk("status idle write", IDX_STS, 32'h0000_0000);
		chk("master enable", 32'h1, {31'h0, sclk_oe});
		wait_cc();
		chk("serial out", 32'h0000_3c5a, {16'h0, heard});
		rdchk("mirror", IDX_EMU, 32'h0000_a5c3);
		rdchk("mirror again", IDX_EMU, 32'h0000_a5c3);
		rdchk("status after mirror", IDX_STS, 32'h0000_0040);
		rdchk("rx holding", IDX_RXB, 32'h0000_a5c3);
		rdchk("status after rx", IDX_STS, 32'h0000_0000);
		$display("test full char done");
	endtask

	task automatic t_pend();
		start(16'hffff, 5'd16);
		bus(1'b1, IDX_TXB, 32'h0000_1234);
		bus(1'b1, IDX_TXB, 32'h0000_8421);
		rdchk("status pending", IDX_STS, 32'h0000_0020);
		bus(1'b1, IDX_STS, 32'h0000_0000);
		rdchk("status write ignored", IDX_STS, 32'h0000_0020);
		wait_cc();
		rdchk("status reload", IDX_STS, 32'h0000_0040);
		chk("first char", 32'h0000_1234, {16'h0, heard});
		bus(1'b0, IDX_RXB, 32'h0000_0000);
		wait_cc();
		chk("second char", 32'h0000_8421, {16'h0, heard});
		bus(1'b1, IDX_RXB, 32'h0000_5555);
		rdchk("rx readonly", IDX_RXB, 32'h0000_0000);
		$display("test pending done");
	endtask

	task automatic t_short();
		bus(1'b1, IDX_CTL, 32'h0000_0f87);
		start(16'h6b00, 5'd8);
		bus(1'b1, IDX_TXB, 32'h0000_9600);
		wait_cc();
		chk("short out", 32'h0000_0096, {24'h0, heard[7:0]});
		rdchk("short rx", IDX_RXB, 32'h0000_006b);
		$display("test short char done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		cyc = 0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		reply = 16'h0000;
		nbits = 5'd16;
		arm = 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		arm <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_full();
		t_pend();
		t_short();
		test_done();
	end
endmodule // spi_data_buffer_path_tb
